// >>> rtl/ssrp_defs.svh
// Constants for the sensor serial register port
`ifndef SSRP_DEFS_SVH
`define SSRP_DEFS_SVH
`define SSRP_ADDR_HI 7'h56
`define SSRP_ADDR_LO 7'h70
`define SSRP_HS_BASE 5'h01
`define SSRP_REG_LAST 8'hff
`define SSRP_SPI_LAST 7'h7f
`define SSRP_SPI_PAGE 1'b1
`define SSRP_BIT_LAST 4'h7
`define SSRP_BIT_ACK 4'h8
`define SSRP_BIT_END 4'h9
`define SSRP_SPI_LASTBIT 3'h7
`endif

// >>> rtl/ssrp_pkg.sv
// Types shared by the serial register port modules
package ssrp_pkg;
    typedef enum logic [2:0] {
        SSRP_IDLE,
        SSRP_ADDR,
        SSRP_REG,
        SSRP_WDATA,
        SSRP_RDATA
    } ssrp_i2c_st_t;
    typedef logic [7:0] ssrp_byte_t;
endpackage

// >>> rtl/ssrp_sync.sv
// Two flip-flop level synchroniser
`timescale 1ns/10ps
module ssrp_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] sync_ff
);
    logic [WIDTH-1:0] meta_ff;

    // First stage feeds only the second
    always_ff @(posedge clk) begin
        if (rst) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= d;
            sync_ff <= meta_ff;
        end
    end
endmodule

// >>> rtl/ssrp_spi_link.sv
// Serial-link end running on the link clock
`timescale 1ns/10ps
`include "ssrp_defs.svh"
module ssrp_spi_link import ssrp_pkg::*; (
    input wire logic spi_sck,
    input wire logic spi_csb,
    input wire logic sys_rst,
    input wire logic three_wire,
    input wire logic sdi_i,
    output logic sdi_o,
    output logic sdi_oe,
    output logic sdo_o,
    output logic sdo_oe,
    output logic rd_tgl_ff,
    output logic [6:0] rd_addr_ff,
    input wire logic [7:0] rd_data,
    output logic wr_tgl_ff,
    output logic [6:0] wr_addr_ff,
    output logic [7:0] wr_data_ff
);
    logic [2:0] cnt_ff;
    logic hdr_ff;
    logic read_ff;
    logic [6:0] sh_ff;
    logic [6:0] addr_ff;
    ssrp_byte_t tx_ff;
    logic oe_ff;
    logic tw_s;
    ssrp_byte_t rx;
    logic last;
    logic [6:0] addr_inc;

    assign rx = {sh_ff, sdi_i};
    assign last = (cnt_ff == `SSRP_SPI_LASTBIT);
    // Saturate like the two-wire pointer
    assign addr_inc = (addr_ff == `SSRP_SPI_LAST) ? addr_ff : addr_ff + 7'h01;

    // Mode pin is quasi-static; edges arrive during the header
    ssrp_sync #(.WIDTH(1)) u_tw_sync (
        .clk(spi_sck),
        .rst(1'b0),
        .d(three_wire),
        .sync_ff(tw_s)
    );

    // Frame decode on rising edges, chip select high ends it
    always_ff @(posedge spi_sck or posedge spi_csb) begin
        if (spi_csb) begin
            cnt_ff <= 3'h0;
            hdr_ff <= 1'b0;
            read_ff <= 1'b0;
            sh_ff <= 7'h00;
            addr_ff <= 7'h00;
        end else begin
            sh_ff <= rx[6:0];
            cnt_ff <= cnt_ff + 3'h1;
            if (last) begin
                if (!hdr_ff) begin
                    hdr_ff <= 1'b1;
                    read_ff <= rx[7];
                    addr_ff <= rx[6:0];
                end else if (read_ff) begin
                    addr_ff <= addr_inc;
                end else begin
                    hdr_ff <= 1'b0;
                end
            end
        end
    end

    // Events to the system side; not cleared by chip select
    always_ff @(posedge spi_sck or posedge sys_rst) begin
        if (sys_rst) begin
            rd_tgl_ff <= 1'b0;
            rd_addr_ff <= 7'h00;
            wr_tgl_ff <= 1'b0;
            wr_addr_ff <= 7'h00;
            wr_data_ff <= 8'h00;
        end else if (!spi_csb && last) begin
            if (!hdr_ff) begin
                if (rx[7]) begin
                    rd_addr_ff <= rx[6:0];
                    rd_tgl_ff <= ~rd_tgl_ff;
                end
            end else if (read_ff) begin
                rd_addr_ff <= addr_inc;
                rd_tgl_ff <= ~rd_tgl_ff;
            end else begin
                wr_addr_ff <= addr_ff;
                wr_data_ff <= rx;
                wr_tgl_ff <= ~wr_tgl_ff;
            end
        end
    end

    // Output shifts on falling edges, MSB first
    always_ff @(negedge spi_sck or posedge spi_csb) begin
        if (spi_csb) begin
            tx_ff <= 8'h00;
            oe_ff <= 1'b0;
        end else if (hdr_ff && read_ff && cnt_ff == 3'h0) begin
            tx_ff <= rd_data;
            oe_ff <= 1'b1;
        end else begin
            tx_ff <= {tx_ff[6:0], 1'b0};
        end
    end

    // Pin choice by wiring mode
    assign sdo_o = tx_ff[7];
    assign sdi_o = tx_ff[7];
    assign sdo_oe = oe_ff & ~tw_s;
    assign sdi_oe = oe_ff & tw_s;
endmodule

// >>> rtl/ssrp_top.sv
// Serial register port: two-wire target and serial link
// Overview of operation
// - Bus address 56h if select high, else 70h
// - Eighth address bit: 0 write, 1 read
// - Write sends address/data pairs until stop
// - Return bytes, auto-increment, until host nack
// - Read pointer sticks at FFh
// - Link write: bit 0, address, data byte
// - Many write sets per chip select
// - Chip select high ends link transaction
// - Link read: bit 1, address, data out
// - Three-wire mode drives data on input pin
// - Link read increments address until deselect, sticking at 7Fh
// - Two-wire bus runs standard, fast, high speed
// - 3-bit setting picks master code 08h-0Fh
`timescale 1ns/10ps
`include "ssrp_defs.svh"
module ssrp_top import ssrp_pkg::*; (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    input wire logic addr_sel,
    input wire logic [2:0] hs_code_sel,
    output logic hs_active,
    input wire logic spi_sck,
    input wire logic spi_csb,
    input wire logic spi_three_wire,
    input wire logic spi_sdi_i,
    output logic spi_sdi_o,
    output logic spi_sdi_oe,
    output logic spi_sdo_o,
    output logic spi_sdo_oe,
    output logic reg_we,
    output logic [7:0] reg_waddr,
    output logic [7:0] reg_wdata,
    output logic [7:0] reg_raddr,
    input wire logic [7:0] reg_rdata
);
    // Two-wire address match for the strapped select
    function automatic logic addr_hit(input ssrp_byte_t b,
                                      input logic sel);
        addr_hit = (b[7:1] == (sel ? `SSRP_ADDR_HI : `SSRP_ADDR_LO));
    endfunction

    // Synchronised pins and link events
    logic [4:0] sync_q;
    logic scl_s;
    logic sda_s;
    logic sel_s;
    logic rd_tgl_s;
    logic wr_tgl_s;
    logic scl_d_ff;
    logic sda_d_ff;
    logic rd_tgl_d_ff;
    logic wr_tgl_d_ff;

    // Link-side signals, stable once their toggle is seen
    logic link_rd_tgl;
    logic [6:0] link_rd_addr;
    logic link_wr_tgl;
    logic [6:0] link_wr_addr;
    ssrp_byte_t link_wr_data;
    ssrp_byte_t spi_rdata_ff;

    // Two-wire engine state
    ssrp_i2c_st_t st_ff;
    ssrp_i2c_st_t nxt_st;
    logic [3:0] cnt_ff;
    ssrp_byte_t sh_ff;
    ssrp_byte_t ptr_ff;
    ssrp_byte_t tx_ff;
    logic ack_me_ff;
    logic sda_oe_ff;
    logic hs_ff;
    logic i2c_pend_ff;
    ssrp_byte_t i2c_waddr_ff;
    ssrp_byte_t i2c_wdata_ff;
    logic reg_we_ff;
    ssrp_byte_t reg_waddr_ff;
    ssrp_byte_t reg_wdata_ff;

    // Decoded bus events
    logic scl_rise;
    logic scl_fall;
    logic start_ev;
    logic stop_ev;
    logic byte_done;
    logic ack_rise;
    logic ack_fall;
    logic end_fall;
    logic host_slot;
    logic rd_ev;
    logic wr_ev;
    ssrp_byte_t rx_byte;

    // Pins and link toggles cross here
    ssrp_sync #(.WIDTH(5)) u_sync (
        .clk(clk),
        .rst(sys_rst),
        .d({addr_sel, ~scl_i, ~sda_i, link_rd_tgl, link_wr_tgl}),
        .sync_ff(sync_q)
    );

    // Bus pins cross inverted: a cleared stage reads as idle high,
    // so no false clock edge or stop follows reset
    assign sel_s = sync_q[4];
    assign scl_s = ~sync_q[3];
    assign sda_s = ~sync_q[2];
    assign rd_tgl_s = sync_q[1];
    assign wr_tgl_s = sync_q[0];

    // Link end on its own clock
    ssrp_spi_link u_link (
        .spi_sck(spi_sck),
        .spi_csb(spi_csb),
        .sys_rst(sys_rst),
        .three_wire(spi_three_wire),
        .sdi_i(spi_sdi_i),
        .sdi_o(spi_sdi_o),
        .sdi_oe(spi_sdi_oe),
        .sdo_o(spi_sdo_o),
        .sdo_oe(spi_sdo_oe),
        .rd_tgl_ff(link_rd_tgl),
        .rd_addr_ff(link_rd_addr),
        .rd_data(spi_rdata_ff),
        .wr_tgl_ff(link_wr_tgl),
        .wr_addr_ff(link_wr_addr),
        .wr_data_ff(link_wr_data)
    );

    // Delayed copies for edge detection
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            scl_d_ff <= 1'b1;
            sda_d_ff <= 1'b1;
            rd_tgl_d_ff <= 1'b0;
            wr_tgl_d_ff <= 1'b0;
        end else begin
            scl_d_ff <= scl_s;
            sda_d_ff <= sda_s;
            rd_tgl_d_ff <= rd_tgl_s;
            wr_tgl_d_ff <= wr_tgl_s;
        end
    end

    // Sampling at 250 MHz covers every bus rate
    assign scl_rise = scl_s & ~scl_d_ff;
    assign scl_fall = ~scl_s & scl_d_ff;
    // Start and stop need the clock high on both samples
    assign start_ev = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
    assign stop_ev = scl_s & scl_d_ff & ~sda_d_ff & sda_s;
    assign rx_byte = {sh_ff[6:0], sda_s};
    assign byte_done = scl_rise && cnt_ff == `SSRP_BIT_LAST;
    assign ack_rise = scl_rise && cnt_ff == `SSRP_BIT_ACK;
    assign ack_fall = scl_fall && cnt_ff == `SSRP_BIT_ACK;
    assign end_fall = scl_fall && cnt_ff == `SSRP_BIT_END;
    // Ack slot owned by the host during read data
    assign host_slot = ack_rise && st_ff == SSRP_RDATA && !ack_me_ff;
    assign rd_ev = rd_tgl_s ^ rd_tgl_d_ff;
    assign wr_ev = wr_tgl_s ^ wr_tgl_d_ff;

    // Next transfer phase
    always_comb begin
        nxt_st = st_ff;
        if (stop_ev) begin
            nxt_st = SSRP_IDLE;
        end else if (start_ev) begin
            nxt_st = SSRP_ADDR;
        end else if (byte_done) begin
            unique case (st_ff)
                SSRP_ADDR: begin
                    if (addr_hit(rx_byte, sel_s)) begin
                        nxt_st = rx_byte[0] ? SSRP_RDATA : SSRP_REG;
                    end else begin
                        nxt_st = SSRP_IDLE;
                    end
                end
                SSRP_REG: nxt_st = SSRP_WDATA;
                SSRP_WDATA: nxt_st = SSRP_REG;
                SSRP_RDATA: nxt_st = SSRP_RDATA;
                SSRP_IDLE: nxt_st = SSRP_IDLE;
            endcase
        end else if (host_slot && sda_s) begin
            nxt_st = SSRP_IDLE;
        end
    end

    // Phase register
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_ff <= SSRP_IDLE;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Bit counter: 0-7 data, 8 ack clock, 9 ack done
    // Start or stop anywhere realigns the count
    always_ff @(posedge clk) begin
        if (sys_rst || start_ev || stop_ev) begin
            cnt_ff <= 4'h0;
        end else if (scl_rise && cnt_ff < `SSRP_BIT_ACK) begin
            cnt_ff <= cnt_ff + 4'h1;
        end else if (ack_rise) begin
            cnt_ff <= `SSRP_BIT_END;
        end else if (end_fall) begin
            cnt_ff <= 4'h0;
        end
    end

    // Shift in on rising clock, MSB first
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sh_ff <= 8'h00;
        end else if (scl_rise && cnt_ff < `SSRP_BIT_ACK) begin
            sh_ff <= rx_byte;
        end
    end

    // Whether this ack slot is ours to drive
    always_ff @(posedge clk) begin
        if (sys_rst || start_ev || stop_ev) begin
            ack_me_ff <= 1'b0;
        end else if (byte_done) begin
            ack_me_ff <= (st_ff == SSRP_ADDR && addr_hit(rx_byte, sel_s))
                         || st_ff == SSRP_REG || st_ff == SSRP_WDATA;
        end else if (end_fall) begin
            ack_me_ff <= 1'b0;
        end
    end

    // Master code is never acked; holds until stop
    always_ff @(posedge clk) begin
        if (sys_rst || stop_ev) begin
            hs_ff <= 1'b0;
        end else if (byte_done && st_ff == SSRP_ADDR
                     && rx_byte == {`SSRP_HS_BASE, hs_code_sel}) begin
            hs_ff <= 1'b1;
        end
    end

    // Register pointer; kept across a repeated start
    // Stops at FFh rather than wrapping to 00h
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ptr_ff <= 8'h00;
        end else if (byte_done && st_ff == SSRP_REG) begin
            ptr_ff <= rx_byte;
        end else if (host_slot && !sda_s
                     && ptr_ff != `SSRP_REG_LAST) begin
            ptr_ff <= ptr_ff + 8'h01;
        end
    end

    // Read byte, loaded as the ack slot ends
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            tx_ff <= 8'h00;
        end else if (end_fall && st_ff == SSRP_RDATA) begin
            tx_ff <= reg_rdata;
        end else if (scl_fall && cnt_ff != 4'h0
                     && cnt_ff < `SSRP_BIT_ACK) begin
            tx_ff <= {tx_ff[6:0], 1'b0};
        end
    end

    // Open drain: enable pulls low for ack or a zero bit
    always_ff @(posedge clk) begin
        if (sys_rst || start_ev || stop_ev) begin
            sda_oe_ff <= 1'b0;
        end else if (ack_fall) begin
            sda_oe_ff <= ack_me_ff;
        end else if (end_fall) begin
            sda_oe_ff <= (st_ff == SSRP_RDATA) && !reg_rdata[7];
        end else if (scl_fall && cnt_ff != 4'h0 && cnt_ff < `SSRP_BIT_ACK
                     && st_ff == SSRP_RDATA) begin
            sda_oe_ff <= !tx_ff[6];
        end
    end

    // Paired data byte waits for the shared write port
    // Held one more cycle while a link write owns it
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            i2c_pend_ff <= 1'b0;
            i2c_waddr_ff <= 8'h00;
            i2c_wdata_ff <= 8'h00;
        end else if (byte_done && st_ff == SSRP_WDATA) begin
            i2c_pend_ff <= 1'b1;
            i2c_waddr_ff <= ptr_ff;
            i2c_wdata_ff <= rx_byte;
        end else if (!wr_ev) begin
            i2c_pend_ff <= 1'b0;
        end
    end

    // Link writes go first; the bus write waits a cycle
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            reg_we_ff <= 1'b0;
            reg_waddr_ff <= 8'h00;
            reg_wdata_ff <= 8'h00;
        end else if (wr_ev) begin
            reg_we_ff <= 1'b1;
            reg_waddr_ff <= {`SSRP_SPI_PAGE, link_wr_addr};
            reg_wdata_ff <= link_wr_data;
        end else begin
            reg_we_ff <= i2c_pend_ff;
            reg_waddr_ff <= i2c_waddr_ff;
            reg_wdata_ff <= i2c_wdata_ff;
        end
    end

    // Link read: fetch in the event cycle, hold for the link
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            spi_rdata_ff <= 8'h00;
        end else if (rd_ev) begin
            spi_rdata_ff <= reg_rdata;
        end
    end

    // Read address follows the active requester
    // Limitation: a bus fetch in that same cycle sees the link's byte
    assign reg_raddr = rd_ev ? {`SSRP_SPI_PAGE, link_rd_addr} : ptr_ff;

    // Outputs straight from their registers
    assign reg_we = reg_we_ff;
    assign reg_waddr = reg_waddr_ff;
    assign reg_wdata = reg_wdata_ff;
    // Open drain: pin value always low, only the enable moves
    assign sda_o = 1'b0;
    assign sda_oe = sda_oe_ff;
    assign hs_active = hs_ff;
endmodule

// >>> verif/ssrp_chk.sv
// Assertion checker for the serial register port
`timescale 1ns/10ps
module ssrp_chk (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sda_oe,
    input wire logic hs_active,
    input wire logic spi_sck,
    input wire logic spi_csb,
    input wire logic spi_three_wire,
    input wire logic spi_sdi_oe,
    input wire logic spi_sdo_o,
    input wire logic spi_sdo_oe
);
    // All checks run on the system clock
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    property p_cs_end;
        $rose(spi_csb) |-> ##[0:2] !(spi_sdo_oe || spi_sdi_oe);
    endproperty
    a_cs_end: assert property (p_cs_end)
        else $error("link pin driven after deselect");
    property p_cs_idle;
        spi_csb ##1 spi_csb |-> !spi_sdo_oe && !spi_sdi_oe;
    endproperty
    a_cs_idle: assert property (p_cs_idle)
        else $error("link pin driven while idle");
    property p_3w_pin;
        spi_sdi_oe |-> spi_three_wire && !spi_sdo_oe;
    endproperty
    a_3w_pin: assert property (p_3w_pin)
        else $error("data in pin driven in four-wire mode");
    property p_4w_pin;
        spi_sdo_oe |-> !spi_three_wire;
    endproperty
    a_4w_pin: assert property (p_4w_pin)
        else $error("data out pin driven in three-wire mode");
    property p_rd_hold;
        spi_sdo_oe && !spi_csb |=> spi_sdo_oe || spi_csb;
    endproperty
    a_rd_hold: assert property (p_rd_hold)
        else $error("read output dropped inside frame");
    // Output may only move after a falling link clock edge; the first
    // sample after a rise is included so a rising-edge shift is caught
    property p_sck_hi;
        spi_sck && !spi_csb && !$past(spi_csb) |-> $stable(spi_sdo_o);
    endproperty
    a_sck_hi: assert property (p_sck_hi)
        else $error("link output moved while clock high");
    property p_hs_stop;
        scl_i && $past(scl_i) && $rose(sda_i) |-> ##[1:8] !hs_active;
    endproperty
    a_hs_stop: assert property (p_hs_stop)
        else $error("high-speed flag kept after stop");
    // Device data may change only while the bus clock is low
    property p_sda_hold;
        scl_i [*6] |-> $stable(sda_oe);
    endproperty
    a_sda_hold: assert property (p_sda_hold)
        else $error("data pin moved while bus clock high");
endmodule

bind ssrp_top ssrp_chk ssrp_chk_inst (.clk(clk), .sys_rst(sys_rst), .scl_i(scl_i),
    .sda_i(sda_i), .sda_oe(sda_oe), .hs_active(hs_active), .spi_sck(spi_sck),
    .spi_csb(spi_csb), .spi_three_wire(spi_three_wire), .spi_sdi_oe(spi_sdi_oe),
    .spi_sdo_o(spi_sdo_o), .spi_sdo_oe(spi_sdo_oe));

// >>> verif/ssrp_host.sv
// Behavioural host driving the two-wire bus and the serial link
`timescale 1ns/10ps
module ssrp_host (
    input wire logic clk,
    input wire logic sda_in,
    input wire logic miso,
    output logic scl,
    output logic sda_h,
    output logic sck,
    output logic csb,
    output logic sdi_h,
    output logic sdi_drv
);
    // Idle: bus released, link clock parked low outside frames
    initial begin
        scl = 1'b1;
        sda_h = 1'b1;
        sck = 1'b0;
        csb = 1'b1;
        sdi_h = 1'b0;
        sdi_drv = 1'b0;
    end
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask
    // One bus bit; data only moves while the clock is low
    task automatic ibit(input logic b, output logic r);
        sda_h <= b;
        wt(10);
        scl <= 1'b1;
        wt(10);
        r = sda_in;
        wt(10);
        scl <= 1'b0;
        wt(10);
    endtask
    // Eight bits MSB first, then the ninth bit driven with ha
    task automatic ibyte(input logic [7:0] d, input logic ha, output logic [7:0] r,
        output logic ak);
        for (int i = 7; i >= 0; i--) ibit(d[i], r[i]);
        ibit(ha, ak);
    endtask
    // Start, also usable as repeated start
    task automatic istart();
        sda_h <= 1'b1;
        wt(10);
        scl <= 1'b1;
        wt(10);
        sda_h <= 1'b0;
        wt(10);
        scl <= 1'b0;
        wt(10);
    endtask
    // Every transfer ends with a stop
    task automatic istop();
        sda_h <= 1'b0;
        wt(10);
        scl <= 1'b1;
        wt(10);
        sda_h <= 1'b1;
        wt(20);
    endtask
    // Link frame of n bits; sdi released after rel bits, set on falling sck
    task automatic sxfer(input int n, input int rel, input logic [31:0] d,
        output logic [31:0] r);
        r = '0;
        #6.3 csb = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            sdi_drv = (n - 1 - i) < rel;
            sdi_h = d[i];
            #40 sck = 1'b1;
            r[i] = miso;
            #40 sck = 1'b0;
        end
        sdi_drv = 1'b0;
        #40 csb = 1'b1;
        #120;
    endtask
endmodule

// >>> verif/tb_sensor_serial_register_port.sv
// Self-checking bench for the serial register port
`timescale 1ns/10ps
module tb_sensor_serial_register_port;
    logic clk, sys_rst, addr_sel, three;
    logic [2:0] hs_sel;
    wire scl, sda_h, sck, csb, h_sdi, h_drv, sda_o, sda_oe, hs_act;
    wire sdi_o, sdi_oe, sdo_o, sdo_oe, we, sda_w, sdi_w, sdo_w, miso;
    wire [7:0] waddr, wdata, raddr, rdata;
    int err_count, checked;
    logic [15:0] exp_q[$];

    // Register space answers with a fixed scramble of its address
    function automatic logic [7:0] rf(input logic [7:0] a);
        return {a[3:0], a[7:4]} ^ 8'h3c;
    endfunction
    assign rdata = rf(raddr);
    // Open-drain bus with pull-up; link lines pulled up when released in 3-wire
    assign sda_w = sda_h & (sda_oe ? sda_o : 1'b1);
    assign sdi_w = sdi_oe ? sdi_o : (h_drv ? h_sdi : (three ? 1'b1 : ~h_sdi));
    assign sdo_w = sdo_oe ? sdo_o : 1'b1;
    assign miso = three ? sdi_w : sdo_w;

    ssrp_top ssrp_top_inst (.clk(clk), .sys_rst(sys_rst), .scl_i(scl), .sda_i(sda_w),
        .sda_o(sda_o), .sda_oe(sda_oe), .addr_sel(addr_sel), .hs_code_sel(hs_sel),
        .hs_active(hs_act), .spi_sck(sck), .spi_csb(csb), .spi_three_wire(three),
        .spi_sdi_i(sdi_w), .spi_sdi_o(sdi_o), .spi_sdi_oe(sdi_oe), .spi_sdo_o(sdo_o),
        .spi_sdo_oe(sdo_oe), .reg_we(we), .reg_waddr(waddr), .reg_wdata(wdata),
        .reg_raddr(raddr), .reg_rdata(rdata));
    ssrp_host ssrp_host_inst (.clk(clk), .sda_in(sda_w), .miso(miso), .scl(scl),
        .sda_h(sda_h), .sck(sck), .csb(csb), .sdi_h(h_sdi), .sdi_drv(h_drv));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic fail(input string m);
        err_count++;
        $display("[FAIL] %0t %s", $time, m);
    endtask
    task automatic chk1(input logic g, input logic e, input string m);
        checked++;
        if (g !== e) fail(m);
    endtask
    task automatic chk8(input logic [7:0] g, input logic [7:0] e, input string m);
        checked++;
        if (g !== e) fail(m);
    endtask
    task automatic chk16(input logic [15:0] g, input logic [15:0] e, input string m);
        checked++;
        if (g !== e) fail(m);
    endtask
    // Every write pulse is matched against the model queue
    always @(posedge clk) begin
        if (!sys_rst && we === 1'b1) begin
            if (exp_q.size() == 0) fail("unexpected write");
            else chk16({waddr, wdata}, exp_q.pop_front(), "write");
        end
    end
    // Bounded wait for all expected writes
    task automatic drain();
        for (int i = 0; i < 100 && exp_q.size() > 0; i++) @(posedge clk);
        if (exp_q.size() != 0) begin
            fail("missing write");
            final_report();
        end
    endtask
    // Bus write of two register/data pairs; ex says whether dev should answer
    task automatic iw(input logic [6:0] dev, input logic [7:0] a, input logic [7:0] d,
        input logic ex);
        logic [7:0] r;
        logic k;
        if (ex) exp_q.push_back({a, d});
        if (ex) exp_q.push_back({~a, ~d});
        ssrp_host_inst.istart();
        ssrp_host_inst.ibyte({dev, 1'b0}, 1'b1, r, k);
        chk1(k, !ex, "address ack");
        ssrp_host_inst.ibyte(a, 1'b1, r, k);
        ssrp_host_inst.ibyte(d, 1'b1, r, k);
        ssrp_host_inst.ibyte(~a, 1'b1, r, k);
        ssrp_host_inst.ibyte(~d, 1'b1, r, k);
        ssrp_host_inst.istop();
        drain();
    endtask
    // Bus read of four bytes from p, low strap address; rs: repeated start, else stop+start
    task automatic ir(input logic [7:0] p, input logic rs);
        logic [7:0] r, e;
        logic k;
        ssrp_host_inst.istart();
        ssrp_host_inst.ibyte({7'h70, 1'b0}, 1'b1, r, k);
        ssrp_host_inst.ibyte(p, 1'b1, r, k);
        chk1(k, 1'b0, "register byte ack");
        if (!rs) ssrp_host_inst.istop();
        ssrp_host_inst.istart();
        ssrp_host_inst.ibyte({7'h70, 1'b1}, 1'b1, r, k);
        chk1(k, 1'b0, "read address ack");
        e = p;
        for (int i = 0; i < 4; i++) begin
            ssrp_host_inst.ibyte(8'hff, i == 3, r, k);
            chk8(r, rf(e), "bus read");
            if (e != 8'hff) e++;
        end
        ssrp_host_inst.istop();
        drain();
    endtask

    initial begin
        logic [7:0] a0, d0, r8, e;
        logic [31:0] r;
        logic ak;
        sys_rst <= 1'b1;
        addr_sel <= 1'b1;
        three <= 1'b0;
        hs_sel <= 3'h0;
        a0 = 8'($urandom(74214));
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (3) @(posedge clk);
        // Both strap levels, matching and foreign address
        for (int s = 1; s >= 0; s--) begin
            addr_sel <= 1'(s);
            iw(7'h56, 8'($urandom), 8'($urandom), 1'(s));
            iw(7'h70, 8'($urandom), 8'($urandom), 1'(1 - s));
        end
        ir(8'hfd, 1'b1);
        ir(8'($urandom), 1'b0);
        // Every master code; even passes use a mismatching setting
        for (int s = 0; s < 8; s++) begin
            hs_sel <= s[0] ? 3'(s) : 3'(s + 1);
            ssrp_host_inst.istart();
            ssrp_host_inst.ibyte(8'h08 + 8'(s), 1'b1, r8, ak);
            chk1(ak, 1'b1, "code acked");
            chk1(hs_act, s[0], "code flag");
            ssrp_host_inst.istop();
            chk1(hs_act, 1'b0, "code flag after stop");
        end
        // Two link write sets in one frame, then a cut-short frame
        a0 = 8'($urandom);
        d0 = 8'($urandom);
        exp_q.push_back({1'b1, a0[6:0], d0});
        exp_q.push_back({1'b1, ~a0[6:0], ~d0});
        ssrp_host_inst.sxfer(32, 32, {1'b0, a0[6:0], d0, 1'b0, ~a0[6:0], ~d0}, r);
        drain();
        ssrp_host_inst.sxfer(12, 12, {20'h0, 1'b0, a0[6:0], d0[7:4]}, r);
        // Link reads in four- and three-wire mode, pointer saturating
        for (int m = 0; m < 2; m++) begin
            three <= 1'(m);
            a0 = m == 0 ? 8'h7e : 8'($urandom);
            @(posedge clk);
            ssrp_host_inst.sxfer(32, 8, {1'b1, a0[6:0], 24'h0}, r);
            e = {1'b1, a0[6:0]};
            for (int k = 0; k < 3; k++) begin
                chk8(r[23 - 8 * k -: 8], rf(e), "link read");
                if (e != 8'hff) e++;
            end
        end
        final_report();
    end
    // Hang guard
    initial begin
        #400000;
        fail("timeout");
        final_report();
    end
endmodule
